// >>> mse_exec.v
// Summary of operation
// - Subtract memory: acc plus inverted memory plus one into acc, update ov z ac c.
// - Subtract to memory: same sum written back to memory byte, all four flags updated.
// - Subtract immediate: acc plus inverted immediate plus one into acc, four flags.
// - Nibble swap in place on memory byte, no flag changes.
// - Nibble swap into accumulator, memory and flags untouched.
// - A met skip adds one dummy cycle: two cycles, else one.
// - Skip when memory byte is zero, nothing modified.
// - Copy memory byte to acc, skip when it is zero, flags kept.
// - Skip when selected memory bit is zero, nothing modified.
// - Table read current page: low byte to memory, high byte to latch.
// - Table read final page: low byte to memory, high byte to latch.
// - Acc xor memory into acc, only zero flag updated.
// - Acc xor memory into memory, only zero flag updated.
// - Acc xor immediate into acc, only zero flag updated.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mse_map.vh"

module mse_exec (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ******************************
  // State codes
  // ******************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_DUMMY = 2'b10;

  // ******************************
  // Storage and core state
  // ******************************
  reg [7:0] data_mem [0:255];
  reg [15:0] rom_mem [0:511];
  reg [1:0] state;
  reg [15:0] instr;
  reg [7:0] acc;
  reg c_flag;
  reg aux_carry_flag;
  reg z_flag;
  reg signed_wrap_flag;
  reg skip_taken;
  reg [7:0] table_pointer;
  reg [7:0] table_high_byte_latch;
  reg page;
  reg [7:0] mem_addr;
  reg [8:0] rom_addr;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // Subtract by complement-add: {ov, ac, c, result}
  function [10:0] sub_calc;
    input [7:0] a;
    input [7:0] m;
    reg [8:0] sum;
    reg [4:0] low;
    begin
      sum = {1'b0, a} + {1'b0, ~m} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
      sub_calc = {(a[7] == ~m[7]) && (sum[7] != a[7]), low[4], sum[8], sum[7:0]};
    end
  endfunction

  // Exchange the two nibbles of a byte
  function [7:0] swap_nib;
    input [7:0] v;
    begin
      swap_nib = {v[3:0], v[7:4]};
    end
  endfunction

  // Merge byte lanes of a write into an old value
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ******************************
  // Instruction decode
  // ******************************
  wire [3:0] opc;
  wire [2:0] bit_sel;
  wire [7:0] arg;
  wire [7:0] mem_byte;
  wire [15:0] rom_word;
  wire [10:0] sub_m;
  wire [10:0] sub_i;
  wire [7:0] xor_m;
  wire [7:0] xor_i;

  assign opc = instr[`MSE_OP_MSB:`MSE_OP_LSB];
  assign bit_sel = instr[`MSE_BIT_MSB:`MSE_BIT_LSB];
  assign arg = instr[`MSE_ARG_MSB:`MSE_ARG_LSB];
  assign mem_byte = data_mem[arg];
  assign sub_m = sub_calc(acc, mem_byte);
  assign sub_i = sub_calc(acc, arg);
  assign xor_m = acc ^ mem_byte;
  assign xor_i = acc ^ arg;
  // Current page or the final page, word picked by the table pointer
  assign rom_word = (opc == `MSE_OPC_TAB_FINAL) ? rom_mem[{`MSE_FINAL_PAGE, table_pointer}] :
                    rom_mem[{page, table_pointer}];

  // Skip condition of the instruction in execution
  reg skip_met;
  always @* begin
    case (opc)
      `MSE_OPC_SKIP_NULL: skip_met = (mem_byte == `MSE_ZERO8);
      `MSE_OPC_COPY_SKIP: skip_met = (mem_byte == `MSE_ZERO8);
      `MSE_OPC_SKIP_BIT: skip_met = ~mem_byte[bit_sel];
      default: skip_met = 1'b0;
    endcase
  end

  // ******************************
  // Bus handshake helpers
  // ******************************
  wire bus_commit;
  wire [31:0] wr_word;
  assign bus_commit = aw_held && w_held && !s_axi_bvalid && (state == ST_IDLE);
  assign wr_word = lane_merge(`MSE_ZERO32, w_data, w_strb);

  // Window writes merged into the old byte or word, cut to storage width below
  wire [31:0] mem_merged;
  wire [31:0] rom_merged;
  assign mem_merged = lane_merge({24'h000000, data_mem[mem_addr]}, w_data, w_strb);
  assign rom_merged = lane_merge({16'h0000, rom_mem[rom_addr]}, w_data, w_strb);

  // Read-back view of registers
  reg [31:0] rd_word;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_word = `MSE_ZERO32;
    case (s_axi_araddr)
      `MSE_ADDR_INSTR: rd_word[15:0] = instr;
      `MSE_ADDR_ACC: rd_word[7:0] = acc;
      `MSE_ADDR_STATUS: begin
        rd_word[`MSE_ST_C] = c_flag;
        rd_word[`MSE_ST_AC] = aux_carry_flag;
        rd_word[`MSE_ST_Z] = z_flag;
        rd_word[`MSE_ST_OV] = signed_wrap_flag;
        rd_word[`MSE_ST_BUSY] = (state != ST_IDLE);
        rd_word[`MSE_ST_SKIP] = skip_taken;
      end
      `MSE_ADDR_TPTR: rd_word[7:0] = table_pointer;
      `MSE_ADDR_THIGH: rd_word[7:0] = table_high_byte_latch;
      `MSE_ADDR_PAGE: rd_word[0] = page;
      `MSE_ADDR_MADDR: rd_word[7:0] = mem_addr;
      `MSE_ADDR_MDATA: rd_word[7:0] = data_mem[mem_addr];
      `MSE_ADDR_RADDR: rd_word[8:0] = rom_addr;
      `MSE_ADDR_RDATA: rd_word[15:0] = rom_mem[rom_addr];
      default: rd_hit = 1'b0;
    endcase
  end

  // ******************************
  // Write address and data channels
  // ******************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= `MSE_ZERO8;
      w_data <= `MSE_ZERO32;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (bus_commit) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `MSE_ADDR_RDATA || aw_addr[1:0] != 2'b00 || aw_addr == `MSE_ADDR_THIGH) ?
                       `MSE_RESP_SLVERR : `MSE_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ******************************
  // Read channel
  // ******************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `MSE_ZERO32;
      s_axi_rresp <= `MSE_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ******************************
  // Sequencer and register writes
  // ******************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      instr <= `MSE_ZERO16;
      acc <= `MSE_ZERO8;
      c_flag <= 1'b0;
      aux_carry_flag <= 1'b0;
      z_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      skip_taken <= 1'b0;
      table_pointer <= `MSE_ZERO8;
      table_high_byte_latch <= `MSE_ZERO8;
      page <= 1'b0;
      mem_addr <= `MSE_ZERO8;
      rom_addr <= 9'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (bus_commit) begin
            case (aw_addr)
              `MSE_ADDR_INSTR: begin
                instr <= wr_word[15:0];
                skip_taken <= 1'b0;
                state <= ST_EXEC;
              end
              `MSE_ADDR_ACC: acc <= wr_word[7:0];
              `MSE_ADDR_STATUS: begin
                c_flag <= wr_word[`MSE_ST_C];
                aux_carry_flag <= wr_word[`MSE_ST_AC];
                z_flag <= wr_word[`MSE_ST_Z];
                signed_wrap_flag <= wr_word[`MSE_ST_OV];
              end
              `MSE_ADDR_TPTR: table_pointer <= wr_word[7:0];
              `MSE_ADDR_PAGE: page <= wr_word[0];
              `MSE_ADDR_MADDR: mem_addr <= wr_word[7:0];
              `MSE_ADDR_RADDR: rom_addr <= wr_word[8:0];
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_EXEC: begin
          skip_taken <= skip_met;
          state <= skip_met ? ST_DUMMY : ST_IDLE;
          case (opc)
            `MSE_OPC_SUB_MEM: begin
              acc <= sub_m[7:0];
              {signed_wrap_flag, aux_carry_flag, c_flag} <= sub_m[10:8];
              z_flag <= (sub_m[7:0] == `MSE_ZERO8);
            end
            `MSE_OPC_SUB_TO_MEM: begin
              {signed_wrap_flag, aux_carry_flag, c_flag} <= sub_m[10:8];
              z_flag <= (sub_m[7:0] == `MSE_ZERO8);
            end
            `MSE_OPC_SUB_IMM: begin
              acc <= sub_i[7:0];
              {signed_wrap_flag, aux_carry_flag, c_flag} <= sub_i[10:8];
              z_flag <= (sub_i[7:0] == `MSE_ZERO8);
            end
            `MSE_OPC_SWAP_ACC: acc <= swap_nib(mem_byte);
            `MSE_OPC_COPY_SKIP: acc <= mem_byte;
            `MSE_OPC_TAB_CUR: table_high_byte_latch <= rom_word[15:8];
            `MSE_OPC_TAB_FINAL: table_high_byte_latch <= rom_word[15:8];
            `MSE_OPC_XOR_MEM: begin
              acc <= xor_m;
              z_flag <= (xor_m == `MSE_ZERO8);
            end
            `MSE_OPC_XOR_TO_MEM: z_flag <= (xor_m == `MSE_ZERO8);
            `MSE_OPC_XOR_IMM: begin
              acc <= xor_i;
              z_flag <= (xor_i == `MSE_ZERO8);
            end
            default: acc <= acc;
          endcase
        end
        ST_DUMMY: state <= ST_IDLE; // Flushed fetch slot
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ******************************
  // Data memory and table store writes
  // ******************************
  always @(posedge aclk) begin
    if (state == ST_EXEC) begin
      case (opc)
        `MSE_OPC_SUB_TO_MEM: data_mem[arg] <= sub_m[7:0];
        `MSE_OPC_SWAP_MEM: data_mem[arg] <= swap_nib(mem_byte);
        `MSE_OPC_TAB_CUR: data_mem[arg] <= rom_word[7:0];
        `MSE_OPC_TAB_FINAL: data_mem[arg] <= rom_word[7:0];
        `MSE_OPC_XOR_TO_MEM: data_mem[arg] <= xor_m;
        default: data_mem[arg] <= mem_byte;
      endcase
    end else if (bus_commit && aw_addr == `MSE_ADDR_MDATA) begin
      data_mem[mem_addr] <= mem_merged[7:0];
    end
    if (bus_commit && aw_addr == `MSE_ADDR_RDATA) begin
      rom_mem[rom_addr] <= rom_merged[15:0];
    end
  end

endmodule // mse_exec

`default_nettype wire

// >>> mse_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mse_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
// ****************************
// Bench top
// ****************************
module mse_exec_bench;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, slow = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tp;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] exp_q[$], e;
  logic [15:0] w0, w1;
  int bad_count = 0, checked = 0;

  mse_exec DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // Clock
  always #5 aclk = ~aclk;

  // Compare each answer with the oldest note
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      e = exp_q.pop_front();
      if (s_axi_rvalid) `CHK({s_axi_rresp, s_axi_rdata}, e)
      else `CHK({s_axi_bresp, 32'h0}, e)
    end
  end

  // Bus write with optional answer stall
  task automatic wr(input [7:0] ad, input [31:0] d, input [1:0] r = `MSE_RESP_OKAY);
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!s_axi_bready && (!slow || $urandom % 2)) s_axi_bready <= 1'h1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
  endtask

  // Bus read with random answer stall
  task automatic rd(input [7:0] ad, input [31:0] d, input [1:0] r = `MSE_RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (!s_axi_rready && $urandom % 2) s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
  endtask

  function automatic [11:0] subf(input [7:0] a, input [7:0] v);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'h0, a} + {1'h0, ~v} + 9'h1;
    h = {1'h0, a[3:0]} + {1'h0, ~v[3:0]} + 5'h1;
    subf = {a[7] != v[7] && r[7] != a[7], r[7:0] == 8'h00, h[4], r[8], r[7:0]};
  endfunction

  // One instruction with random operands and full result check
  task automatic run(input [3:0] op, input bit p);
    logic [7:0] a, m, x, ea, em, arg;
    logic [3:0] f, st;
    logic [2:0] b;
    logic [11:0] s;
    logic sk;
    a = 8'($urandom);
    m = p ? 8'h00 : 8'($urandom);
    x = 8'($urandom);
    b = 3'($urandom);
    st = 4'($urandom);
    wr(`MSE_ADDR_ACC, {24'h0, a});
    wr(`MSE_ADDR_MADDR, 32'h10);
    wr(`MSE_ADDR_MDATA, {24'h0, m});
    wr(`MSE_ADDR_STATUS, {28'h0, st});
    s = subf(a, op == 4'h2 ? x : m);
    ea = a;
    em = m;
    f = st;
    sk = 1'h0;
    arg = 8'h10;
    case (op)
      4'h0: {f, ea} = s;
      4'h1: {f, em} = s;
      4'h2: begin {f, ea} = s; arg = x; end
      4'h3: em = {m[3:0], m[7:4]};
      4'h4: ea = {m[3:0], m[7:4]};
      4'h5: sk = m == 8'h00;
      4'h6: begin ea = m; sk = m == 8'h00; end
      4'h7: sk = !m[b];
      4'h8: em = w0[7:0];
      4'h9: em = w1[7:0];
      4'hA: begin ea = a ^ m; f[2] = ea == 8'h00; end
      4'hB: begin em = a ^ m; f[2] = em == 8'h00; end
      4'hC: begin ea = a ^ x; f[2] = ea == 8'h00; arg = x; end
      default: ;
    endcase
    slow = 1'h0;
    // Status taken one cycle after execution: busy still set only by a dummy cycle
    fork
      wr(`MSE_ADDR_INSTR, {16'h0, arg, 1'h0, b, op});
      begin
        repeat (3) @(posedge aclk);
        rd(`MSE_ADDR_STATUS, {22'h0, sk, sk, 4'h0, f});
      end
    join
    wr(`MSE_ADDR_MADDR, 32'h10);
    slow = 1'h1;
    rd(`MSE_ADDR_ACC, {24'h0, ea});
    rd(`MSE_ADDR_MDATA, {24'h0, em});
    rd(`MSE_ADDR_STATUS, {22'h0, sk, 5'h0, f});
    if (op == 4'h8) rd(`MSE_ADDR_THIGH, {24'h0, w0[15:8]});
    if (op == 4'h9) rd(`MSE_ADDR_THIGH, {24'h0, w1[15:8]});
  endtask

  task wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end

  // Main sequence
  initial begin
    void'($urandom(17810));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`MSE_ADDR_ACC, 32'h0);
    rd(`MSE_ADDR_STATUS, 32'h0);
    rd(`MSE_ADDR_THIGH, 32'h0);
    wr(`MSE_ADDR_THIGH, 32'h1, `MSE_RESP_SLVERR);
    rd(8'h30, 32'h0, `MSE_RESP_SLVERR);
    tp = 8'($urandom);
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    wr(`MSE_ADDR_TPTR, {24'h0, tp});
    wr(`MSE_ADDR_RADDR, {24'h0, tp});
    wr(`MSE_ADDR_RDATA, {16'h0, w0});
    wr(`MSE_ADDR_RADDR, {23'h0, 1'h1, tp});
    wr(`MSE_ADDR_RDATA, {16'h0, w1});
    wr(`MSE_ADDR_PAGE, 32'h0);
    for (int p = 0; p < 2; p++)
      for (int op = 0; op < 14; op++) run(4'(op), p[0]);
    wrap_up;
  end
endmodule // mse_exec_bench
`default_nettype wire

// >>> mse_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Bus handshake checks
// ****************************
module mse_exec_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answers one cycle after the address is taken
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read open");
  // Write answer stands and blocks new writes
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write open");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad error read");
  wr_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad code");
  c_rd_c: cover property (s_axi_rvalid && !s_axi_rready);
  c_werr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_rerr_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // mse_exec_props

bind mse_exec mse_exec_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> mse_map.vh
`ifndef MSE_MAP_VH
`define MSE_MAP_VH

// ******************************
// Register byte addresses
// ******************************
`define MSE_ADDR_INSTR 8'h00
`define MSE_ADDR_ACC 8'h04
`define MSE_ADDR_STATUS 8'h08
`define MSE_ADDR_TPTR 8'h0C
`define MSE_ADDR_THIGH 8'h10
`define MSE_ADDR_PAGE 8'h14
`define MSE_ADDR_MADDR 8'h18
`define MSE_ADDR_MDATA 8'h1C
`define MSE_ADDR_RADDR 8'h20
`define MSE_ADDR_RDATA 8'h24

// ******************************
// Instruction word fields
// ******************************
`define MSE_OP_MSB 3
`define MSE_OP_LSB 0
`define MSE_BIT_MSB 6
`define MSE_BIT_LSB 4
`define MSE_ARG_MSB 15
`define MSE_ARG_LSB 8

// ******************************
// Status register fields
// ******************************
`define MSE_ST_C 0
`define MSE_ST_AC 1
`define MSE_ST_Z 2
`define MSE_ST_OV 3
`define MSE_ST_BUSY 8
`define MSE_ST_SKIP 9

// ******************************
// Operation codes
// ******************************
`define MSE_OPC_SUB_MEM 4'h0
`define MSE_OPC_SUB_TO_MEM 4'h1
`define MSE_OPC_SUB_IMM 4'h2
`define MSE_OPC_SWAP_MEM 4'h3
`define MSE_OPC_SWAP_ACC 4'h4
`define MSE_OPC_SKIP_NULL 4'h5
`define MSE_OPC_COPY_SKIP 4'h6
`define MSE_OPC_SKIP_BIT 4'h7
`define MSE_OPC_TAB_CUR 4'h8
`define MSE_OPC_TAB_FINAL 4'h9
`define MSE_OPC_XOR_MEM 4'hA
`define MSE_OPC_XOR_TO_MEM 4'hB
`define MSE_OPC_XOR_IMM 4'hC

// ******************************
// Sizes, answers and reset values
// ******************************
`define MSE_FINAL_PAGE 1'b1
`define MSE_RESP_OKAY 2'h0
`define MSE_RESP_SLVERR 2'h2
`define MSE_ZERO8 8'h00
`define MSE_ZERO16 16'h0000
`define MSE_ZERO32 32'h00000000

`endif
